/* File: ccr_defs.vh */
// constants for the cpu context register block
`ifndef CCR_DEFS_VH
`define CCR_DEFS_VH
`define CCR_ADDR_PTR_ONE 8'h80
`define CCR_ADDR_PTR_TWO 8'h81
`define CCR_ADDR_SLOT_ONE 8'h82
`define CCR_ADDR_SLOT_TWO 8'h83
`define CCR_ADDR_ACC 8'hff
`define CCR_RESET_VECTOR 12'h0ffe
`define CCR_BYTE_ZERO 8'h00
`define CCR_PC_ONE 12'h001
`define CCR_STACK_DEPTH 6
`define CCR_CTX_NORMAL 3'b001
`define CCR_CTX_IRQ 3'b010
`define CCR_CTX_NMI 3'b100
`define CCR_ALU_NONE 3'h0
`define CCR_ALU_ARITH 3'h1
`define CCR_ALU_LOGIC 3'h2
`define CCR_ALU_BITTEST 3'h3
`define CCR_ALU_ROTATE 3'h4
`endif

/* File: ccr_stack.v */
// six-level return stack with registered top output
`timescale 1ns/10ps
`default_nettype none
module ccr_stack #(
  parameter WIDTH = 12,
  parameter DEPTH = 6
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // control
  input wire push,
  input wire pop,
  input wire [WIDTH-1:0] push_data,
  // state
  output reg [WIDTH-1:0] top_r,
  output reg [3:0] depth_r
);
  reg [WIDTH-1:0] level_r [0:DEPTH-1];
  // neighbour values each level takes on a push or a pop
  wire [WIDTH-1:0] from_above [0:DEPTH-1];
  wire [WIDTH-1:0] from_below [0:DEPTH-1];
  // parameter is 32 bits wide; only the low nibble is compared
  wire [31:0] depth_full = DEPTH;
  wire can_pop = (depth_r != 4'd0);
  genvar g;
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : lvl
      if (g == 0) begin : top_lvl
        assign from_above[g] = push_data;
      end else begin : inner_lvl
        assign from_above[g] = level_r[g-1];
      end
      if (g == DEPTH-1) begin : bottom_lvl
        assign from_below[g] = {WIDTH{1'b0}};
      end else begin : upper_lvl
        assign from_below[g] = level_r[g+1];
      end
      always @(posedge mclk) begin
        if (rst) begin
          level_r[g] <= {WIDTH{1'b0}};
        end else if (push) begin
          level_r[g] <= from_above[g];
        end else if (pop && can_pop) begin
          level_r[g] <= from_below[g];
        end
      end
    end
  endgenerate
  always @(posedge mclk) begin
    if (rst) begin
      depth_r <= 4'd0;
      top_r <= {WIDTH{1'b0}};
    end else if (push) begin
      top_r <= push_data;
      if (depth_r != depth_full[3:0]) begin
        depth_r <= depth_r + 4'd1;
      end
    end else if (pop && can_pop) begin
      depth_r <= depth_r - 4'd1;
      top_r <= from_below[0];
    end
  end
endmodule // ccr_stack
`default_nettype wire

/* File: ccr_context_regs.v */
// cpu context registers: data-space regs, pc, banked flags, return stack
`timescale 1ns/10ps
`default_nettype none
`include "ccr_defs.vh"
module ccr_context_regs #(
  parameter PC_W = 12,
  parameter STACK_DEPTH = `CCR_STACK_DEPTH
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // data space access
  input wire [7:0] ds_addr,
  input wire ds_wr,
  input wire [7:0] ds_wdata,
  output reg [7:0] ds_rdata_r,
  output reg ds_hit_r,
  // program counter control
  input wire pc_inc,
  input wire pc_rel,
  input wire [7:0] rel_offset,
  input wire pc_load,
  input wire [PC_W-1:0] pc_target,
  input wire call_push,
  input wire irq_take,
  input wire nmi_take,
  input wire [PC_W-1:0] vector,
  input wire subroutine_return,
  input wire return_from_interrupt,
  // flag update from the alu
  input wire [2:0] alu_op,
  input wire alu_carry,
  input wire [7:0] alu_result,
  input wire tested_bit,
  // state
  output reg [PC_W-1:0] pc_r,
  output reg carry_r,
  output reg zero_r,
  output reg [2:0] ctx_r,
  output reg [7:0] acc_r,
  output reg [3:0] stack_depth_r
);
  reg [7:0] ptr_one_r, ptr_two_r, slot_one_r, slot_two_r;
  reg normal_carry, normal_zero, irq_carry, irq_zero;
  reg nonmaskable_carry, nonmaskable_zero;
  reg [2:0] ctx_saved_r;
  reg [2:0] ctx_nxt;
  reg [PC_W-1:0] pc_nxt;
  reg c_nxt, z_nxt, c_cur, z_cur;
  reg upd_c, upd_z;
  wire [PC_W-1:0] stk_top;
  wire [3:0] stk_depth;
  wire is_return = subroutine_return | return_from_interrupt;
  wire do_push = call_push | irq_take | nmi_take;
  wire stk_empty = (stk_depth == 4'd0);

  function is_addr;
    input [7:0] lhs;
    input [7:0] rhs;
    begin
      is_addr = (lhs == rhs);
    end
  endfunction

  // one decode per mapped location, shared by write and read ports
  wire hit_acc = is_addr(ds_addr, `CCR_ADDR_ACC);
  wire hit_ptr_one = is_addr(ds_addr, `CCR_ADDR_PTR_ONE);
  wire hit_ptr_two = is_addr(ds_addr, `CCR_ADDR_PTR_TWO);
  wire hit_slot_one = is_addr(ds_addr, `CCR_ADDR_SLOT_ONE);
  wire hit_slot_two = is_addr(ds_addr, `CCR_ADDR_SLOT_TWO);
  wire ds_mapped = hit_acc | hit_ptr_one | hit_ptr_two | hit_slot_one | hit_slot_two;

  // sequential and relative targets; offset is two's complement
  wire [PC_W-1:0] pc_seq = pc_r + `CCR_PC_ONE;
  wire [PC_W-1:0] pc_branch = pc_r + {{(PC_W-8){rel_offset[7]}}, rel_offset};

  // one-hot context decode picks which banked pair may change
  wire in_normal = (ctx_r == `CCR_CTX_NORMAL);
  wire in_irq = (ctx_r == `CCR_CTX_IRQ);
  wire in_nmi = (ctx_r == `CCR_CTX_NMI);

  // only pc goes on the stack; data regs untouched
  ccr_stack #(.WIDTH(PC_W), .DEPTH(STACK_DEPTH)) u_stack (
    .mclk(mclk),
    .rst(rst),
    .push(do_push),
    .pop(is_return),
    .push_data(pc_r),
    .top_r(stk_top),
    .depth_r(stk_depth)
  );

  // data-space registers
  always @(posedge mclk) begin
    if (rst) begin
      acc_r <= `CCR_BYTE_ZERO;
      ptr_one_r <= `CCR_BYTE_ZERO;
      ptr_two_r <= `CCR_BYTE_ZERO;
      slot_one_r <= `CCR_BYTE_ZERO;
      slot_two_r <= `CCR_BYTE_ZERO;
    end else if (ds_wr) begin
      if (hit_acc) acc_r <= ds_wdata;
      if (hit_ptr_one) ptr_one_r <= ds_wdata;
      if (hit_ptr_two) ptr_two_r <= ds_wdata;
      if (hit_slot_one) slot_one_r <= ds_wdata;
      if (hit_slot_two) slot_two_r <= ds_wdata;
    end
  end

  // read data registered; hit marks this block owns the address
  always @(posedge mclk) begin
    if (rst) begin
      ds_rdata_r <= `CCR_BYTE_ZERO;
      ds_hit_r <= 1'b0;
    end else begin
      ds_hit_r <= ds_mapped;
      if (hit_acc) begin
        ds_rdata_r <= acc_r;
      end else if (hit_ptr_one) begin
        ds_rdata_r <= ptr_one_r;
      end else if (hit_ptr_two) begin
        ds_rdata_r <= ptr_two_r;
      end else if (hit_slot_one) begin
        ds_rdata_r <= slot_one_r;
      end else if (hit_slot_two) begin
        ds_rdata_r <= slot_two_r;
      end else begin
        ds_rdata_r <= `CCR_BYTE_ZERO;
      end
    end
  end

  // program counter next value; priority reset > entry > return > load > rel > inc
  always @* begin
    pc_nxt = pc_r;
    if (irq_take || nmi_take) begin
      pc_nxt = vector;
    end else if (is_return) begin
      // empty stack: fall through to next instruction
      if (stk_empty) begin
        pc_nxt = pc_seq;
      end else begin
        pc_nxt = stk_top;
      end
    end else if (pc_load) begin
      pc_nxt = pc_target;
    end else if (pc_rel) begin
      pc_nxt = pc_branch;
    end else if (pc_inc) begin
      pc_nxt = pc_seq;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      pc_r <= `CCR_RESET_VECTOR;
    end else begin
      pc_r <= pc_nxt;
    end
  end

  // context selection; one level of saved context covers irq under normal
  always @* begin
    ctx_nxt = ctx_r;
    if (nmi_take) begin
      ctx_nxt = `CCR_CTX_NMI;
    end else if (irq_take) begin
      ctx_nxt = `CCR_CTX_IRQ;
    end else if (return_from_interrupt) begin
      ctx_nxt = ctx_saved_r;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      ctx_r <= `CCR_CTX_NMI;
      ctx_saved_r <= `CCR_CTX_NORMAL;
    end else begin
      ctx_r <= ctx_nxt;
      // only one level saved: a third nesting returns to normal
      if (nmi_take || irq_take) ctx_saved_r <= ctx_r;
      else if (return_from_interrupt) ctx_saved_r <= `CCR_CTX_NORMAL;
    end
  end

  // selected pair drives the visible flags; others are unreachable
  always @* begin
    case (ctx_r)
      `CCR_CTX_NORMAL: begin
        c_cur = normal_carry;
        z_cur = normal_zero;
      end
      `CCR_CTX_IRQ: begin
        c_cur = irq_carry;
        z_cur = irq_zero;
      end
      `CCR_CTX_NMI: begin
        c_cur = nonmaskable_carry;
        z_cur = nonmaskable_zero;
      end
      default: begin
        c_cur = nonmaskable_carry;
        z_cur = nonmaskable_zero;
      end
    endcase
  end

  always @* begin
    c_nxt = c_cur;
    z_nxt = z_cur;
    upd_c = 1'b0;
    upd_z = 1'b0;
    case (alu_op)
      `CCR_ALU_ARITH: begin
        c_nxt = alu_carry;
        z_nxt = (alu_result == `CCR_BYTE_ZERO);
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      `CCR_ALU_ROTATE: begin
        c_nxt = alu_carry;
        z_nxt = (alu_result == `CCR_BYTE_ZERO);
        upd_c = 1'b1;
        upd_z = 1'b1;
      end
      `CCR_ALU_LOGIC: begin
        z_nxt = (alu_result == `CCR_BYTE_ZERO);
        upd_z = 1'b1;
      end
      `CCR_ALU_BITTEST: begin
        c_nxt = tested_bit;
        upd_c = 1'b1;
      end
      default: begin
        upd_c = 1'b0;
      end
    endcase
  end

  // banked pairs; a switch never writes them
  always @(posedge mclk) begin
    if (rst) begin
      normal_carry <= 1'b0;
      normal_zero <= 1'b0;
      irq_carry <= 1'b0;
      irq_zero <= 1'b0;
      nonmaskable_carry <= 1'b0;
      nonmaskable_zero <= 1'b0;
    end else begin
      // an op in the switch cycle still lands on the outgoing pair
      if (in_normal) begin
        if (upd_c) normal_carry <= c_nxt;
        if (upd_z) normal_zero <= z_nxt;
      end
      if (in_irq) begin
        if (upd_c) irq_carry <= c_nxt;
        if (upd_z) irq_zero <= z_nxt;
      end
      if (in_nmi) begin
        if (upd_c) nonmaskable_carry <= c_nxt;
        if (upd_z) nonmaskable_zero <= z_nxt;
      end
    end
  end

  // registered view of active flags and stack depth
  always @(posedge mclk) begin
    if (rst) begin
      carry_r <= 1'b0;
      zero_r <= 1'b0;
      stack_depth_r <= 4'd0;
    end else begin
      carry_r <= c_cur;
      zero_r <= z_cur;
      stack_depth_r <= stk_depth;
    end
  end
endmodule // ccr_context_regs
`default_nettype wire

/* File: ccr_alu_model.sv */
// adder standing in for the core alu on the far side
`timescale 1ns/10ps
`default_nettype none
module ccr_alu_model (
  // operands
  input wire logic [7:0] op_a,
  input wire logic [7:0] op_b,
  // result
  output logic [7:0] sum,
  output logic cout
);
  assign {cout, sum} = op_a + op_b;
endmodule // ccr_alu_model
`default_nettype wire

/* File: ccr_checker.sv */
// assertions on the context register ports
`timescale 1ns/10ps
`default_nettype none
module ccr_checker #(
  parameter PC_W = 12
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // data space
  input wire [7:0] ds_addr,
  input wire ds_wr,
  input wire [7:0] ds_wdata,
  input wire [7:0] ds_rdata_r,
  input wire ds_hit_r,
  // pc control
  input wire pc_inc,
  input wire pc_rel,
  input wire [7:0] rel_offset,
  input wire pc_load,
  input wire [PC_W-1:0] pc_target,
  input wire call_push,
  input wire irq_take,
  input wire nmi_take,
  input wire [PC_W-1:0] vector,
  input wire subroutine_return,
  input wire return_from_interrupt,
  // state
  input wire [PC_W-1:0] pc_r,
  input wire [2:0] ctx_r,
  input wire [7:0] acc_r,
  input wire [3:0] stack_depth_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire take = irq_take | nmi_take;
  wire pop = subroutine_return | return_from_interrupt;
  wire hi = take | pop | pc_load;
  wire map = ds_addr[7:2] == 6'h20 || ds_addr == 8'hff;
  wire [PC_W-1:0] inc_pc = pc_r + 1'b1;
  wire [PC_W-1:0] rel_pc = pc_r + {{(PC_W-8){rel_offset[7]}}, rel_offset};
  sequence call_s;
    call_push && pc_load && !take && !pop;
  endsequence
  sequence ret_s;
    subroutine_return && !take && !call_push;
  endsequence
  reset_state_a: assert property (disable iff (1'b0) rst |=> pc_r == 12'h0ffe && ctx_r == 3'b100)
    else $error("reset state wrong");
  pc_step_a: assert property (pc_inc && !hi && !pc_rel |=> pc_r == $past(inc_pc))
    else $error("pc increment wrong");
  pc_rel_a: assert property (pc_rel && !hi |=> pc_r == $past(rel_pc))
    else $error("relative branch wrong");
  pc_load_a: assert property (pc_load && !take && !pop |=> pc_r == $past(pc_target))
    else $error("pc load wrong");
  irq_entry_a: assert property (take |=> pc_r == $past(vector) && ctx_r == ($past(nmi_take) ? 3'b100 : 3'b010))
    else $error("interrupt entry wrong");
  acc_write_a: assert property (ds_wr && ds_addr == 8'hff |=> acc_r == $past(ds_wdata))
    else $error("accumulator write lost");
  addr_hit_a: assert property (!rst |=> ds_hit_r == $past(map))
    else $error("decode hit wrong");
  unmapped_read_a: assert property (!rst && !map |=> ds_rdata_r == 8'h00)
    else $error("unmapped read not zero");
  depth_cap_a: assert property (stack_depth_r <= 4'h6)
    else $error("stack depth above six");
  call_return_a: assert property (call_s ##1 ret_s |=> pc_r == $past(pc_r, 2))
    else $error("return address wrong");
endmodule // ccr_checker
bind ccr_context_regs ccr_checker #(.PC_W(PC_W)) u_chk (.mclk(mclk), .rst(rst), .ds_addr(ds_addr), .ds_wr(ds_wr),
  .ds_wdata(ds_wdata), .ds_rdata_r(ds_rdata_r), .ds_hit_r(ds_hit_r), .pc_inc(pc_inc), .pc_rel(pc_rel),
  .rel_offset(rel_offset), .pc_load(pc_load), .pc_target(pc_target), .call_push(call_push), .irq_take(irq_take),
  .nmi_take(nmi_take), .vector(vector), .subroutine_return(subroutine_return),
  .return_from_interrupt(return_from_interrupt), .pc_r(pc_r), .ctx_r(ctx_r), .acc_r(acc_r),
  .stack_depth_r(stack_depth_r));
`default_nettype wire

/* File: cpu_context_registers_tb.sv */
// self-checking bench for the cpu context registers
`timescale 1ns/10ps
`default_nettype none
module cpu_context_registers_tb;
  localparam logic [7:0] IRQ = 8'h80, NMI = 8'h40, POP_SUB = 8'h20, POP_INT = 8'h10;
  localparam logic [7:0] CALL = 8'h0c, LOAD = 8'h04, REL = 8'h02, INC = 8'h01;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ds_wr = 1'b0, tested_bit = 1'b0, ds_hit_r, carry_r, zero_r, alu_carry;
  logic [7:0] ds_addr = 8'h00, ds_wdata = 8'h00, rel_offset = 8'h00, op_a = 8'h00, op_b = 8'h00;
  logic [7:0] ctl = 8'h00, ds_rdata_r, alu_result, acc_r;
  logic [2:0] alu_op = 3'h0, ctx_r;
  logic [11:0] pc_target = 12'h000, vector = 12'h010, pc_r;
  logic [3:0] stack_depth_r;
  int fails = 0, num_checks = 0, cyc = 0;
  always #4 mclk = ~mclk;
  ccr_alu_model u_alu (.op_a(op_a), .op_b(op_b), .sum(alu_result), .cout(alu_carry));
  ccr_context_regs dut (.mclk(mclk), .rst(rst), .ds_addr(ds_addr), .ds_wr(ds_wr), .ds_wdata(ds_wdata),
    .ds_rdata_r(ds_rdata_r), .ds_hit_r(ds_hit_r), .pc_inc(ctl[0]), .pc_rel(ctl[1]), .rel_offset(rel_offset),
    .pc_load(ctl[2]), .pc_target(pc_target), .call_push(ctl[3]), .irq_take(ctl[7]), .nmi_take(ctl[6]),
    .vector(vector), .subroutine_return(ctl[5]), .return_from_interrupt(ctl[4]), .alu_op(alu_op),
    .alu_carry(alu_carry), .alu_result(alu_result), .tested_bit(tested_bit), .pc_r(pc_r), .carry_r(carry_r),
    .zero_r(zero_r), .ctx_r(ctx_r), .acc_r(acc_r), .stack_depth_r(stack_depth_r));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one control pulse, then a spare edge so late flags and depth settle
  task automatic step(input logic [7:0] pulse, input logic [2:0] op, input logic [11:0] t);
    @(posedge mclk);
    ctl <= pulse;
    alu_op <= op;
    pc_target <= t;
    rel_offset <= t[7:0];
    @(posedge mclk);
    ctl <= 8'h00;
    alu_op <= 3'h0;
    @(posedge mclk);
    #1;
  endtask
  task automatic alu(input logic [7:0] lhs, input logic [7:0] rhs, input logic t);
    @(posedge mclk);
    op_a <= lhs;
    op_b <= rhs;
    tested_bit <= t;
  endtask
  task automatic wr_rd(input logic [7:0] addr, input logic [7:0] d, input logic [7:0] exp);
    @(posedge mclk);
    ds_addr <= addr;
    ds_wr <= 1'b1;
    ds_wdata <= d;
    @(posedge mclk);
    ds_wr <= 1'b0;
    @(posedge mclk);
    #1;
    chk(ds_rdata_r, exp);
    chk(ds_hit_r, exp != 8'h00);
  endtask
  task automatic t_reset;
    chk({pc_r, stack_depth_r}, 16'hffe0);
    chk(ctx_r, 3'b100);
  endtask
  task automatic t_regs;
    wr_rd(8'h80, 8'h3c, 8'h3c);
    wr_rd(8'h81, 8'hc3, 8'hc3);
    wr_rd(8'h82, 8'h5a, 8'h5a);
    wr_rd(8'h83, 8'ha5, 8'ha5);
    wr_rd(8'hff, 8'h96, 8'h96);
    wr_rd(8'h84, 8'h77, 8'h00);
    chk(acc_r, 8'h96);
  endtask
  task automatic t_pc;
    step(LOAD, 3'h0, 12'h123); chk(pc_r, 12'h123);
    step(INC, 3'h0, 12'h000); chk(pc_r, 12'h124);
    step(REL, 3'h0, 12'h0fe); chk(pc_r, 12'h122);
    step(REL, 3'h0, 12'h07f); chk(pc_r, 12'h1a1);
    step(LOAD | INC, 3'h0, 12'hfff); chk(pc_r, 12'hfff);
    step(INC, 3'h0, 12'h000); chk(pc_r, 12'h000);
  endtask
  task automatic t_stack;
    for (int i = 0; i < 7; i++) step(CALL, 3'h0, 12'h200 + 12'(i));
    chk(stack_depth_r, 4'h6);
    for (int i = 5; i >= 0; i--) begin
      step(POP_SUB, 3'h0, 12'h000); chk(pc_r, 12'h200 + 12'(i));
    end
    step(POP_SUB, 3'h0, 12'h000); chk({pc_r, stack_depth_r}, 16'h2010);
    @(posedge mclk);
    ctl <= CALL;
    pc_target <= 12'h3ab;
    @(posedge mclk);
    ctl <= POP_SUB;
    @(posedge mclk);
    ctl <= 8'h00;
    @(posedge mclk);
    #1;
    chk(pc_r, 12'h201);
  endtask
  task automatic t_flags;
    alu(8'hff, 8'h01, 1'b0);
    step(8'h00, 3'h1, 12'h000); chk({ctx_r, carry_r, zero_r}, 5'h13);
    step(POP_INT, 3'h0, 12'h000); chk({ctx_r, carry_r, zero_r}, 5'h04);
    alu(8'h90, 8'h80, 1'b1);
    step(8'h00, 3'h1, 12'h000); chk({ctx_r, carry_r, zero_r}, 5'h06);
    step(IRQ, 3'h0, 12'h000); chk({ctx_r, carry_r, zero_r, pc_r}, 17'h08010);
    step(8'h00, 3'h3, 12'h000); chk({ctx_r, carry_r, zero_r}, 5'h0a);
    alu(8'h00, 8'h00, 1'b0);
    step(8'h00, 3'h2, 12'h000); chk({ctx_r, carry_r, zero_r}, 5'h0b);
    step(NMI, 3'h0, 12'h000); chk({ctx_r, carry_r, zero_r}, 5'h13);
    step(POP_INT, 3'h0, 12'h000); chk({ctx_r, carry_r, zero_r, pc_r}, 17'h0b010);
    step(POP_INT, 3'h0, 12'h000); chk({ctx_r, carry_r, zero_r, pc_r}, 17'h06202);
    alu(8'h80, 8'h80, 1'b0);
    step(8'h00, 3'h4, 12'h000); chk({ctx_r, carry_r, zero_r}, 5'h07);
  endtask
  // reset again while the stack and flags hold state
  task automatic t_rerst;
    step(CALL, 3'h0, 12'h155);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1;
    chk({ctx_r, carry_r, zero_r, pc_r, stack_depth_r}, 21'h10ffe0);
    chk(acc_r, 8'h00);
  endtask
  task automatic complete_run;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // hang guard, far above the 130 or so cycles the run needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      complete_run;
    end
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    #1;
    t_reset;
    t_regs;
    t_pc;
    t_stack;
    t_flags;
    t_rerst;
    complete_run;
  end
endmodule // cpu_context_registers_tb
`default_nettype wire
